//--- stm_pkg.sv
package timer_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte addresses on the bus
   localparam logic [7:0] ADDR_CTL0    = 8'h00;
   localparam logic [7:0] ADDR_CTL1    = 8'h04;
   localparam logic [7:0] ADDR_CNT_LO  = 8'h08;
   localparam logic [7:0] ADDR_CNT_HI  = 8'h0c;
   localparam logic [7:0] ADDR_CMPA_LO = 8'h10;
   localparam logic [7:0] ADDR_CMPA_HI = 8'h14;

   ////////////////////////////////////////////////////////////////////////////
   // field positions, control register 0
   localparam int PAUSE_BIT = 7;
   localparam int CLKSEL_LSB = 4;
   localparam int ON_BIT = 3;
   localparam int PERIOD_LSB = 0;

   // field positions, control register 1
   localparam int MODE_LSB = 6;
   localparam int OUTFN_LSB = 4;
   localparam int OUTCTL_BIT = 3;
   localparam int POLARITY_BIT = 2;
   localparam int SWAP_BIT = 1;
   localparam int CLRSEL_BIT = 0;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and widths
   localparam logic [7:0] CTL0_RESET = 8'h00;
   localparam logic [7:0] CTL1_RESET = 8'h00;
   localparam int CNT_W = 10;
   localparam int PERIOD_W = 3;
   localparam int PERIOD_SHIFT = 7;

   // prescaler terminal counts
   localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
   localparam logic [5:0] HI_DIV16_LAST = 6'h0f;
   localparam logic [5:0] HI_DIV64_LAST = 6'h3f;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      MODE_COMPARE = 2'b00,
      MODE_CAPTURE = 2'b01,
      MODE_PWM     = 2'b10,
      MODE_TIMER   = 2'b11
   } mode_t;

   typedef enum logic [2:0] {
      CK_SYS_DIV4 = 3'b000,
      CK_SYS      = 3'b001,
      CK_HI_DIV16 = 3'b010,
      CK_HI_DIV64 = 3'b011,
      CK_TBC_A    = 3'b100,
      CK_TBC_B    = 3'b101,
      CK_EXT_RISE = 3'b110,
      CK_EXT_FALL = 3'b111
   } clksel_t;

   typedef struct packed {
      logic [7:0]       ctl0;
      logic [7:0]       ctl1;
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] compareA;
      logic [7:0]       lowBuf;
      logic [1:0]       sysPre;
      logic [5:0]       hiPre;
      logic             extPrev;
      logic             capPrev;
      logic             level;
      logic             pinOut;
      logic             pinOutN;
      logic             flagA;
      logic             flagP;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
   } state_t;

endpackage

//--- standard_timer_module.sv
`timescale 1ns/1ps
`default_nettype none

module standard_timer_module (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // internal clock ticks
   input  wire logic                  highClockTick,
   input  wire logic                  timeBaseTick,
   // timer pins
   input  wire logic                  externalClockPin,
   input  wire logic                  captureInputPin,
   output logic                       timerOutputPin,
   output logic                       timerOutputPinInverted,
   // match events
   output logic                       compareAMatchFlag,
   output logic                       periodMatchFlag
);
   import timer_pkg::*;

   state_t state_r;
   state_t state_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // control fields
   logic                pauseBit;
   clksel_t             clockSelect;
   logic                moduleOn;
   logic [PERIOD_W-1:0] periodSetting;
   mode_t               operatingMode;
   logic [1:0]          outputFunction;
   logic                outputControl;
   logic                outputPolarity;
   logic                periodDutySwap;
   logic                clearSelect;

   assign pauseBit       = state_r.ctl0[PAUSE_BIT];
   assign clockSelect    = clksel_t'(state_r.ctl0[CLKSEL_LSB +: 3]);
   assign moduleOn       = state_r.ctl0[ON_BIT];
   assign periodSetting  = state_r.ctl0[PERIOD_LSB +: PERIOD_W];
   assign operatingMode  = mode_t'(state_r.ctl1[MODE_LSB +: 2]);
   assign outputFunction = state_r.ctl1[OUTFN_LSB +: 2];
   assign outputControl  = state_r.ctl1[OUTCTL_BIT];
   assign outputPolarity = state_r.ctl1[POLARITY_BIT];
   assign periodDutySwap = state_r.ctl1[SWAP_BIT];
   assign clearSelect    = state_r.ctl1[CLRSEL_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   logic       access;
   logic       commit;
   logic       mapped;
   logic [7:0] readByte;

   assign access = psel & penable;
   assign commit = access & state_r.pready;

   always_comb begin
      mapped   = 1'b1;
      readByte = 8'h00;
      unique case (paddr)
         ADDR_CTL0:    readByte = state_r.ctl0;
         ADDR_CTL1:    readByte = state_r.ctl1;
         ADDR_CNT_LO:  readByte = state_r.lowBuf;
         ADDR_CNT_HI:  readByte = {6'h00, state_r.count[9:8]};
         ADDR_CMPA_LO: readByte = state_r.lowBuf;
         ADDR_CMPA_HI: readByte = {6'h00, state_r.compareA[9:8]};
         default:      mapped = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // counter clock selection
   logic tick;
   logic extRise;
   logic extFall;

   assign extRise = externalClockPin & ~state_r.extPrev;
   assign extFall = ~externalClockPin & state_r.extPrev;

   always_comb begin
      unique case (clockSelect)
         CK_SYS_DIV4: tick = state_r.sysPre == SYS_DIV4_LAST;
         CK_SYS:      tick = 1'b1;
         CK_HI_DIV16: tick = highClockTick
                             & (state_r.hiPre[3:0] == HI_DIV16_LAST[3:0]);
         CK_HI_DIV64: tick = highClockTick
                             & (state_r.hiPre == HI_DIV64_LAST);
         CK_TBC_A,
         CK_TBC_B:    tick = timeBaseTick;
         CK_EXT_RISE: tick = extRise;
         CK_EXT_FALL: tick = extFall;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // comparators
   logic [CNT_W:0]   nextCount;
   logic             overflow;
   logic             periodHit;
   logic             compareHit;
   logic             run;
   logic [CNT_W-1:0] periodValue;

   assign run         = moduleOn & ~pauseBit & tick;
   assign nextCount   = {1'b0, state_r.count} + 11'h001;
   assign overflow    = nextCount[CNT_W];
   assign periodValue = {periodSetting, 7'h00};
   assign periodHit   = (periodSetting != 3'h0)
                        & (nextCount[CNT_W-1:0] == periodValue);
   assign compareHit  = (state_r.compareA != 10'h000)
                        & (nextCount[CNT_W-1:0] == state_r.compareA);

   // capture edge
   logic capRise;
   logic capFall;
   logic capEvent;

   assign capRise = captureInputPin & ~state_r.capPrev;
   assign capFall = ~captureInputPin & state_r.capPrev;

   always_comb begin
      unique case (outputFunction)
         2'b00: capEvent = capRise;
         2'b01: capEvent = capFall;
         2'b10: capEvent = capRise | capFall;
         2'b11: capEvent = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   logic clearNow;
   logic setA;
   logic setP;
   logic pwmPeriod;
   logic pwmDuty;
   logic outLevel;

   always_comb begin
      state_nxt = state_r;
      state_nxt.pready  = 1'b0;
      state_nxt.pslverr = 1'b0;
      state_nxt.flagA   = 1'b0;
      state_nxt.flagP   = 1'b0;
      state_nxt.extPrev = externalClockPin;
      state_nxt.capPrev = captureInputPin;
      state_nxt.sysPre  = state_r.sysPre + 2'h1;
      if (highClockTick) begin
         state_nxt.hiPre = state_r.hiPre + 6'h01;
      end
      clearNow  = overflow;
      setA      = compareHit;
      setP      = periodHit;
      pwmPeriod = periodDutySwap ? compareHit : (periodHit | overflow);
      pwmDuty   = periodDutySwap ? periodHit : compareHit;
      outLevel  = state_r.level;

      unique case (operatingMode)
         MODE_COMPARE,
         MODE_TIMER: begin
            if (clearSelect) begin
               clearNow = compareHit;
               setP     = 1'b0;
            end else begin
               clearNow = periodHit | overflow;
            end
            if (operatingMode == MODE_COMPARE && compareHit) begin
               unique case (outputFunction)
                  2'b00: outLevel = state_r.level;
                  2'b01: outLevel = 1'b0;
                  2'b10: outLevel = 1'b1;
                  2'b11: outLevel = ~state_r.level;
               endcase
            end
         end
         MODE_PWM: begin
            clearNow = pwmPeriod;
            unique case (outputFunction)
               2'b00: outLevel = ~outputControl;
               2'b01: outLevel = outputControl;
               2'b10: begin
                  if (pwmPeriod) begin
                     outLevel = outputControl;
                  end else if (pwmDuty) begin
                     outLevel = ~outputControl;
                  end
               end
               2'b11: begin
                  if (compareHit) begin
                     outLevel = ~outputControl;
                  end
               end
            endcase
         end
         MODE_CAPTURE: begin
            clearNow = overflow;
            setA     = 1'b0;
         end
      endcase

      if (run) begin
         state_nxt.count = clearNow ? 10'h000 : nextCount[CNT_W-1:0];
         state_nxt.flagA = setA;
         state_nxt.flagP = setP;
         state_nxt.level = outLevel;
      end else if (moduleOn && operatingMode == MODE_PWM
                   && outputFunction[1] == 1'b0) begin
         state_nxt.level = outLevel;
      end

      if (moduleOn && operatingMode == MODE_CAPTURE && capEvent) begin
         state_nxt.compareA = state_r.count;
         state_nxt.flagA    = 1'b1;
      end

      // bus answer one cycle into the access phase
      if (access && !state_r.pready) begin
         state_nxt.pready  = 1'b1;
         state_nxt.pslverr = ~mapped;
         state_nxt.prdata  = (pwrite || !mapped) ? 32'h0000_0000
                                                 : {24'h000000, readByte};
      end

      if (commit && mapped) begin
         if (pwrite) begin
            unique case (paddr)
               ADDR_CTL0: begin
                  state_nxt.ctl0 = pwdata[7:0];
                  if (pwdata[ON_BIT] && !moduleOn) begin
                     state_nxt.count = 10'h000;
                     state_nxt.level = state_r.ctl1[OUTCTL_BIT];
                     state_nxt.flagA = 1'b0;
                     state_nxt.flagP = 1'b0;
                  end
               end
               ADDR_CTL1:    state_nxt.ctl1 = pwdata[7:0];
               ADDR_CMPA_LO: state_nxt.lowBuf = pwdata[7:0];
               ADDR_CMPA_HI: state_nxt.compareA = {pwdata[1:0],
                                                   state_r.lowBuf};
               default: ;
            endcase
         end else begin
            unique case (paddr)
               ADDR_CNT_HI:  state_nxt.lowBuf = state_r.count[7:0];
               ADDR_CMPA_HI: state_nxt.lowBuf = state_r.compareA[7:0];
               default: ;
            endcase
         end
      end

      // pin drive; held in timer mode
      if (mode_t'(state_nxt.ctl1[MODE_LSB +: 2]) != MODE_TIMER) begin
         state_nxt.pinOut  = state_nxt.level
                             ^ state_nxt.ctl1[POLARITY_BIT];
         state_nxt.pinOutN = ~state_nxt.pinOut;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign prdata                 = state_r.prdata;
   assign pready                 = state_r.pready;
   assign pslverr                = state_r.pslverr;
   assign timerOutputPin         = state_r.pinOut;
   assign timerOutputPinInverted = state_r.pinOutN;
   assign compareAMatchFlag      = state_r.flagA;
   assign periodMatchFlag        = state_r.flagP;

endmodule

`default_nettype wire

//--- stm_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module timer_asserts
   import timer_pkg::*;
(
   // clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // pins and events
   input wire logic        timerOutputPin,
   input wire logic        timerOutputPinInverted,
   input wire logic        compareAMatchFlag,
   input wire logic        periodMatchFlag
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   property p_answer_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_answer_wait: assert property (p_answer_wait)
      else $error("no answer one cycle after access");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready longer than one cycle");
   property p_err_reply;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_err_reply: assert property (p_err_reply)
      else $error("bad refusal reply");
   property p_write_reply;
      pready && pwrite |-> prdata == 32'h0;
   endproperty
   a_write_reply: assert property (p_write_reply)
      else $error("write returned data");
   property p_high_read;
      pready && !pwrite && (paddr == ADDR_CNT_HI || paddr == ADDR_CMPA_HI)
         |-> prdata[31:2] == 30'h0;
   endproperty
   a_high_read: assert property (p_high_read)
      else $error("high byte read has upper bits set");
   property p_pins_apart;
      !$past(rst) |-> timerOutputPinInverted != timerOutputPin;
   endproperty
   a_pins_apart: assert property (p_pins_apart)
      else $error("output pins not complementary");
   property p_period_gap;
      periodMatchFlag |=> !periodMatchFlag [*8];
   endproperty
   a_period_gap: assert property (p_period_gap)
      else $error("period matches too close");
   property p_off_quiet;
      psel && penable && pready && pwrite && paddr == ADDR_CTL0
         && !pwdata[ON_BIT] |=> ##1 (!compareAMatchFlag && !periodMatchFlag) [*3];
   endproperty
   a_off_quiet: assert property (p_off_quiet)
      else $error("match flag while switched off");

   c_flag_a: cover property (compareAMatchFlag);
   c_flag_p: cover property (periodMatchFlag);
   c_refused: cover property (pslverr);
   c_pin_rise: cover property ($rose(timerOutputPin));
endmodule

bind standard_timer_module timer_asserts i_timer_asserts (
   .clock(clock), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timerOutputPin(timerOutputPin),
   .timerOutputPinInverted(timerOutputPinInverted),
   .compareAMatchFlag(compareAMatchFlag), .periodMatchFlag(periodMatchFlag)
);

`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
   import timer_pkg::*;
   logic        clock, rst, psel, penable, pwrite, pready, pslverr, p;
   logic        highClockTick, timeBaseTick, externalClockPin;
   logic        captureInputPin, timerOutputPin, timerOutputPinInverted;
   logic        compareAMatchFlag, periodMatchFlag;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [31:0] seed = 32'hdafa;
   logic [9:0]  cmpVal;
   logic [32:0] expQ[$];
   int          errTotal, totalChecks, n;

   standard_timer_module i_standard_timer_module (
      .clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .highClockTick(highClockTick),
      .timeBaseTick(timeBaseTick), .externalClockPin(externalClockPin),
      .captureInputPin(captureInputPin), .timerOutputPin(timerOutputPin),
      .timerOutputPinInverted(timerOutputPinInverted),
      .compareAMatchFlag(compareAMatchFlag), .periodMatchFlag(periodMatchFlag)
   );

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // random ticks and pin levels every cycle
   always @(posedge clock) begin
      seed <= lfsr(seed);
      highClockTick <= seed[0];
      timeBaseTick <= seed[1];
      externalClockPin <= seed[2];
      captureInputPin <= seed[3];
   end

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      totalChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", totalChecks, errTotal);
      if (errTotal == 0 && totalChecks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // reply monitor: oldest expectation against each answer
   always @(posedge clock) begin
      if (pready === 1'b1) begin
         if (expQ.size() == 0)
            chk({pslverr, prdata}, 33'h1ffffffff);
         else
            chk({pslverr, prdata}, expQ.pop_front());
      end
   end

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [7:0] d, input logic [32:0] e);
      int k;
      expQ.push_back(e);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {seed[31:8], d};
      @(posedge clock);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
         errTotal++;
         results();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] v);
      apb(1'b0, a, 8'h00, {25'h0, v});
   endtask

   task automatic wrPair(input logic [9:0] v);
      wr(ADDR_CMPA_LO, v[7:0]);
      wr(ADDR_CMPA_HI, {6'h00, v[9:8]});
   endtask

   task automatic rdPair(input logic [7:0] hi, input logic [9:0] v);
      rd(hi, {6'h00, v[9:8]});
      rd(hi - 8'h04, v[7:0]);
   endtask

   task automatic waitFlag(input logic useP, output int c);
      c = 0;
      do begin
         @(posedge clock);
         c++;
      end while ((useP ? periodMatchFlag : compareAMatchFlag) !== 1'b1
                 && c < 3000);
      if (c >= 3000) begin
         errTotal++;
         results();
      end
   endtask

   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      rd(ADDR_CTL0, CTL0_RESET);
      rd(ADDR_CTL1, CTL1_RESET);
      apb(1'b1, 8'h18, 8'hff, {1'b1, 32'h0});
      wr(ADDR_CNT_LO, 8'hff);
      wr(ADDR_CNT_HI, 8'h03);
      rdPair(ADDR_CNT_HI, 10'h000);
      cmpVal = seed[9:0];
      wrPair(cmpVal);
      rdPair(ADDR_CMPA_HI, cmpVal);
      wr(ADDR_CMPA_LO, ~cmpVal[7:0]);
      rdPair(ADDR_CMPA_HI, cmpVal);
      cmpVal = seed[9:0];
      wr(ADDR_CTL1, cmpVal[7:0]);
      rd(ADDR_CTL1, cmpVal[7:0]);
      $display("test registers finished");
      wrPair(10'h008);
      for (int i = 0; i < 2; i++) begin
         p = i[0];
         wr(ADDR_CTL1, {5'b00111, p, 2'b01});
         wr(ADDR_CTL0, {1'b0, p ? CK_SYS : CK_SYS_DIV4, 4'h8});
         @(posedge clock);
         chk(33'({timerOutputPin, timerOutputPinInverted}), 33'({~p, p}));
         waitFlag(1'b0, n);
         chk(33'({timerOutputPin, timerOutputPinInverted}), 33'({p, ~p}));
         waitFlag(1'b0, n);
         chk(33'(n), p ? 33'h8 : 33'h20);
         chk(33'({timerOutputPin, timerOutputPinInverted}), 33'({~p, p}));
         wr(ADDR_CTL0, 8'h00);
      end
      $display("test compare finished");
      wr(ADDR_CTL1, 8'h30);
      wrPair(10'h000);
      wr(ADDR_CTL0, 8'h19);
      waitFlag(1'b1, n);
      waitFlag(1'b1, n);
      chk(33'(n), 33'h80);
      chk(33'(timerOutputPin), 33'h0);
      wr(ADDR_CTL0, 8'h00);
      wr(ADDR_CTL1, 8'ha8);
      wrPair(10'h020);
      wr(ADDR_CTL0, 8'h19);
      waitFlag(1'b0, n);
      chk(33'(timerOutputPin), 33'h0);
      waitFlag(1'b1, n);
      chk(33'(n), 33'h60);
      chk(33'(timerOutputPin), 33'h1);
      wr(ADDR_CTL0, 8'h00);
      wr(ADDR_CTL1, 8'haa);
      wrPair(10'h100);
      wr(ADDR_CTL0, 8'h19);
      waitFlag(1'b0, n);
      chk(33'(timerOutputPin), 33'h1);
      waitFlag(1'b1, n);
      chk(33'(n), 33'h80);
      chk(33'(timerOutputPin), 33'h0);
      wr(ADDR_CTL0, 8'h00);
      wr(ADDR_CTL1, 8'hb8);
      wr(ADDR_CTL0, 8'h18);
      @(posedge clock);
      chk(33'(timerOutputPin), 33'h1);
      waitFlag(1'b0, n);
      chk(33'(timerOutputPin), 33'h0);
      wr(ADDR_CTL0, 8'h00);
      $display("test period and pwm finished");
      wr(ADDR_CTL1, 8'h70);
      wr(ADDR_CTL0, 8'h98);
      rdPair(ADDR_CNT_HI, 10'h000);
      wr(ADDR_CTL0, 8'h18);
      wr(ADDR_CTL0, 8'h98);
      rdPair(ADDR_CNT_HI, 10'h004);
      wr(ADDR_CTL0, 8'h18);
      wr(ADDR_CTL0, 8'h98);
      wr(ADDR_CTL0, 8'h10);
      rdPair(ADDR_CNT_HI, 10'h008);
      wr(ADDR_CTL0, 8'h98);
      rdPair(ADDR_CNT_HI, 10'h000);
      rdPair(ADDR_CMPA_HI, 10'h100);
      wr(ADDR_CTL0, 8'h00);
      wr(ADDR_CTL1, 8'h40);
      wr(ADDR_CTL0, 8'h98);
      waitFlag(1'b0, n);
      rdPair(ADDR_CMPA_HI, 10'h000);
      $display("test pause and switch finished");
      results();
   end
endmodule

`default_nettype wire
